// ===== bench/crtc_horizontal_timing_bench.sv
// Self-checking bench for the horizontal timing block and its register ports.
// Assumes crtch_pkg and crtch_top compiled first; one 100 MHz clock.
`timescale 1ns/1ps
module crtc_horizontal_timing_bench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic color = 1'b1;
  logic w8 = 1'b1;
  logic half = 1'b0;
  logic [7:0] io_rdata_o;
  logic io_rvalid_o, ext_access_o, char_tick_o, hdisplay_o, hblank_o, line_end_o;
  logic [8:0] char_count_o;
  logic [9:0] scanline_o, frame_lines, retrace_line;
  logic vretrace_start_o;
  logic [19:0] start_address_o;
  logic [15:0] line_cyc, disp_cyc, blank_cyc;
  logic ext_seen = 1'b0;
  logic [31:0] lfsr = 32'hc372;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  crtch_top i_dut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .io_addr_i(io_addr),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .color_select_i(color),
    .char_width_8_i(w8), .dot_clock_half_i(half), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .ext_access_o(ext_access_o), .char_tick_o(char_tick_o),
    .char_count_o(char_count_o), .hdisplay_o(hdisplay_o), .hblank_o(hblank_o),
    .line_end_o(line_end_o), .scanline_o(scanline_o), .vretrace_start_o(vretrace_start_o),
    .start_address_o(start_address_o));

  crtch_monitor i_mon (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .hdisplay_i(hdisplay_o),
    .hblank_i(hblank_o), .line_end_i(line_end_o), .vretrace_start_i(vretrace_start_o),
    .scanline_i(scanline_o), .line_cyc_o(line_cyc), .disp_cyc_o(disp_cyc),
    .blank_cyc_o(blank_cyc), .frame_lines_o(frame_lines), .retrace_line_o(retrace_line));

  always @(posedge sys_clk) begin
    if (ext_access_o === 1'b1) ext_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic give_verdict();
    $display("Compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Generous ceiling: the longest run is a few tens of lines of at most 352 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  function automatic logic [15:0] port(input logic data);
    return (color ? crtch_pkg::PORT_INDEX_COLOR : crtch_pkg::PORT_INDEX_MONO) + {15'h0, data};
  endfunction

  // Cycles spent over n + off characters in the present character clock mode
  function automatic logic [31:0] line_exp(input logic [7:0] n, input logic [7:0] off);
    return (32'(n) + 32'(off)) * (w8 ? 32'h8 : 32'h9) * (half ? 32'h2 : 32'h1);
  endfunction

  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge sys_clk) #1;
    io_wr = 1'b0;
  endtask

  task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge sys_clk) #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge sys_clk) #1;
    io_rd = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (io_rvalid_o === 1'b1) ok = 1'b1;
      else @(posedge sys_clk) #1;
    end
    d = io_rdata_o;
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d);
    io_write(port(1'b0), {2'h0, idx});
    io_write(port(1'b1), d);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    io_write(port(1'b0), {2'h0, idx});
    io_read(port(1'b1), d, ok);
    chk(d, exp);
  endtask

  task automatic wait_lines(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk) #1;
      while (line_end_o !== 1'b1) @(posedge sys_clk) #1;
    end
    // One more edge so the monitor has taken the last line
    @(posedge sys_clk) #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] d, t, de, bs, be, vt;
    logic [7:0] v [3];
    logic [7:0] sa [4];
    logic ok;
    logic [5:0] ext [5];
    int n;
    ext = '{6'h19, 6'h1a, 6'h1b, 6'h25, 6'h27};
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 3; i++) rd_chk(6'(i), 8'h00);
    io_write(port(1'b0), 8'hc2);
    io_read(port(1'b0), d, ok);
    chk(d, 8'h02);
    // Colour is selected: the mono data port must be deaf
    io_write(16'h03b5, 8'h5a);
    rd_chk(6'h02, 8'h00);
    io_read(16'h03b5, d, ok);
    chk(ok, 1'b0);
    for (int m = 0; m < 2; m++) begin
      color = m[0];
      if (m == 0) begin
        io_write(crtch_pkg::PORT_INDEX_COLOR, 8'h3f);
        io_read(port(1'b0), d, ok);
        chk(d, 8'h02);
      end
      for (int i = 0; i < 3; i++) begin
        v[i] = rnd();
        wr_reg(6'(i), v[i]);
      end
      for (int i = 0; i < 3; i++) rd_chk(6'(i), v[i]);
    end
    wr_reg(crtch_pkg::IDX_VERTICAL_SYNC_END, 8'h80);
    for (int i = 0; i < 3; i++) wr_reg(6'(i), ~v[i]);
    for (int i = 0; i < 3; i++) rd_chk(6'(i), v[i]);
    wr_reg(crtch_pkg::IDX_VERTICAL_SYNC_END, 8'h00);
    wr_reg(6'h00, ~v[0]);
    rd_chk(6'h00, ~v[0]);
    for (int j = 0; j < 6; j++) begin
      ext_seen = 1'b0;
      wr_reg(j < 5 ? ext[j] : crtch_pkg::IDX_START_ADDRESS_HIGH, 8'h00);
      repeat (3) @(posedge sys_clk);
      #1 chk(ext_seen, j < 5);
    end
    foreach (sa[k]) sa[k] = rnd();
    // Bits 5 and 7 cleared to keep the narrow blanking end compare
    sa[2] = sa[2] & 8'h5f;
    wr_reg(crtch_pkg::IDX_START_ADDRESS_LOW, sa[0]);
    wr_reg(crtch_pkg::IDX_START_ADDRESS_HIGH, sa[1]);
    wr_reg(crtch_pkg::IDX_DISPLAY_EXTENSION, sa[2]);
    wr_reg(crtch_pkg::IDX_START_ADDRESS_EXT, sa[3]);
    repeat (3) @(posedge sys_clk);
    #1 chk(start_address_o, {sa[3][7], sa[2][3], sa[2][2], sa[2][0], sa[1], sa[0]});
    // 8-dot, 9-dot, halved dot clock, then wide blanking end; vertical total never shrinks
    for (int m = 0; m < 4; m++) begin
      t = 8'd10 + (rnd() & 8'h07);
      de = 8'd2 + (rnd() & 8'h03);
      bs = de + 8'd1 + (rnd() & 8'h01);
      be = bs + 8'd1 + (rnd() & 8'h03);
      vt = 8'(m + 1) + (rnd() & 8'h01);
      wr_reg(6'h00, t);
      wr_reg(6'h01, de);
      wr_reg(6'h02, bs);
      wr_reg(6'h03, be);
      wr_reg(6'h05, 8'h00);
      wr_reg(6'h06, vt);
      wr_reg(6'h07, 8'h00);
      wr_reg(crtch_pkg::IDX_DISPLAY_EXTENSION, (m == 3) ? 8'h20 : 8'h00);
      w8 = (m != 1);
      half = (m == 2);
      wait_lines(2 * int'(vt) + 6);
      chk(line_cyc, line_exp(t, 8'd5));
      chk(disp_cyc, line_exp(de, 8'd1));
      chk(blank_cyc, line_exp(be - bs, 8'd0));
      chk(frame_lines, 32'(vt) + 32'h2);
      chk(retrace_line, 32'(vt));
      chk(char_count_o, 32'h0);
      n = 1;
      while (char_tick_o !== 1'b1) begin
        @(posedge sys_clk) #1;
        n++;
      end
      chk(n, line_exp(8'd1, 8'd0));
      chk(char_count_o, 32'h1);
    end
    give_verdict();
  end
endmodule // crtc_horizontal_timing_bench

// ===== bench/crtch_monitor.sv
// Passive display monitor model: measures line, blanking and frame timing.
// Assumes the timing outputs are registered on sys_clk_i and never driven back.
`timescale 1ns/1ps
module crtch_monitor (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic hdisplay_i,
  input wire logic hblank_i,
  input wire logic line_end_i,
  input wire logic vretrace_start_i,
  input wire logic [9:0] scanline_i,
  output logic [15:0] line_cyc_o,
  output logic [15:0] disp_cyc_o,
  output logic [15:0] blank_cyc_o,
  output logic [9:0] frame_lines_o,
  output logic [9:0] retrace_line_o
);
  logic [15:0] cyc, disp, blank;
  logic [9:0] lines;

  ////////////////////////////////////////////////////////////////////////////
  // Sums over whole lines, so a one-cycle shift of a level does not matter
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cyc <= 16'h0000;
      disp <= 16'h0000;
      blank <= 16'h0000;
    end else if (line_end_i) begin
      line_cyc_o <= cyc + 16'h0001;
      disp_cyc_o <= disp + {15'h0000, hdisplay_i};
      blank_cyc_o <= blank + {15'h0000, hblank_i};
      cyc <= 16'h0000;
      disp <= 16'h0000;
      blank <= 16'h0000;
    end else begin
      cyc <= cyc + 16'h0001;
      disp <= disp + {15'h0000, hdisplay_i};
      blank <= blank + {15'h0000, hblank_i};
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lines <= 10'h000;
    end else if (vretrace_start_i) begin
      frame_lines_o <= lines + {9'h000, line_end_i};
      retrace_line_o <= scanline_i;
      lines <= 10'h000;
    end else begin
      lines <= lines + {9'h000, line_end_i};
    end
  end
endmodule // crtch_monitor

// ===== hw/crtch_pkg.sv
// Constants for the horizontal timing part of the display timing controller.
// Assumes one system clock that also serves as the video master clock.
package crtch_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // I/O port addresses, mono and colour decode
  localparam logic [15:0] PORT_INDEX_MONO = 16'h03b4;
  localparam logic [15:0] PORT_DATA_MONO = 16'h03b5;
  localparam logic [15:0] PORT_INDEX_COLOR = 16'h03d4;
  localparam logic [15:0] PORT_DATA_COLOR = 16'h03d5;

  ////////////////////////////////////////////////////////////////////////////
  // Register indexes
  localparam logic [5:0] IDX_HORIZONTAL_TOTAL = 6'h00;
  localparam logic [5:0] IDX_HORIZONTAL_DISPLAY_END = 6'h01;
  localparam logic [5:0] IDX_HORIZONTAL_BLANKING_START = 6'h02;
  localparam logic [5:0] IDX_HORIZONTAL_BLANKING_END = 6'h03;
  localparam logic [5:0] IDX_HORIZONTAL_SYNC_END = 6'h05;
  localparam logic [5:0] IDX_VERTICAL_TOTAL = 6'h06;
  localparam logic [5:0] IDX_VERTICAL_OVERFLOW = 6'h07;
  localparam logic [5:0] IDX_START_ADDRESS_HIGH = 6'h0c;
  localparam logic [5:0] IDX_START_ADDRESS_LOW = 6'h0d;
  localparam logic [5:0] IDX_VERTICAL_SYNC_END = 6'h11;
  localparam logic [5:0] IDX_EXT_A = 6'h19;
  localparam logic [5:0] IDX_BLANKING_EXTENSION = 6'h1a;
  localparam logic [5:0] IDX_DISPLAY_EXTENSION = 6'h1b;
  localparam logic [5:0] IDX_START_ADDRESS_EXT = 6'h1d;
  localparam logic [5:0] IDX_EXT_D = 6'h25;
  localparam logic [5:0] IDX_EXT_E = 6'h27;
  // Highest index covered by the write-protect bit
  localparam logic [5:0] IDX_PROTECT_LAST = 6'h07;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int WRITE_PROTECT_BIT = 7;
  localparam int VT_BIT9_POS = 5;
  localparam int VT_BIT8_POS = 0;
  localparam int HBE_BIT5_POS = 7;
  localparam int HBE_WIDE_EN_A_POS = 5;
  localparam int HBE_WIDE_EN_B_POS = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] INDEX_RESET = 6'h00;
  // Total characters per line = horizontal total + 5
  localparam logic [8:0] HTOTAL_OFFSET = 9'h005;
  // Last dot of an 8 or 9 dot character cell
  localparam logic [3:0] DOT_LAST_8 = 4'h7;
  localparam logic [3:0] DOT_LAST_9 = 4'h8;
  // Edges from a taken read to valid read data
  localparam int READ_LATENCY = 2;

endpackage

// ===== hw/crtch_regmem.sv
// Small register memory holding timing controller registers not kept in flops.
// Assumes single clock, synchronous active-high reset; read data registered.
`timescale 1ns/1ps
module crtch_regmem #(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o
);

  localparam int DEPTH = 1 << ADDR_W;

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rdata;
  } crtch_mem_t;

  crtch_mem_t mem_ff;
  crtch_mem_t nxt_mem;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_mem.rdata = mem_ff.mem[rd_addr_i];
    if (wr_en_i) begin
      nxt_mem.mem[wr_addr_i] = wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mem_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
    end
  end

  assign rd_data_o = mem_ff.rdata;

endmodule // crtch_regmem

// ===== hw/crtch_top.sv
// Horizontal timing part of the display timing controller: indexed register
// port pair, character clock, character and scanline counters, blanking.
// Assumes the I/O strobes and sequencer settings come from logic on sys_clk_i,
// which also serves as the video master clock.
//
// Notes on behaviour
// - Six-bit index register selects the register reached through the data port.
// - Ports decode at 3B4/3B5 for mono, 3D4/3D5 for colour select.
// - Indexes 19, 1A, 1B, 25, 27 reach the extension register set.
// - Character clock comes from master clock per configured character width.
// - Character counter compared with eight-bit total sets the line period.
// - Horizontal total holds characters per line minus five.
// - Horizontal timing counts characters; vertical counts advance once per line.
// - Display end holds displayed character clocks minus one.
// - Blanking begins at the programmed blanking start character count.
// - Total, display end, blanking start ignore writes while write-protect set.
// - Wide fields are assembled from overflow and extension bits.
// - Blanking ends when compared counter bits match blanking end field.
// - Vertical retrace begins when scanline count equals ten-bit vertical total.
`timescale 1ns/1ps
module crtch_top (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic color_select_i,
  input wire logic char_width_8_i,
  input wire logic dot_clock_half_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  output logic ext_access_o,
  output logic char_tick_o,
  output logic [8:0] char_count_o,
  output logic hdisplay_o,
  output logic hblank_o,
  output logic line_end_o,
  output logic [9:0] scanline_o,
  output logic vretrace_start_o,
  output logic [19:0] start_address_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [5:0] index;
    logic [7:0] htotal;
    logic [7:0] hdisp_end;
    logic [7:0] hblank_start;
    logic [7:0] hblank_end_reg;
    logic [7:0] hsync_end_reg;
    logic [7:0] vtotal_reg;
    logic [7:0] vert_overflow;
    logic [7:0] start_addr_high;
    logic [7:0] start_addr_low;
    logic [7:0] vsync_end_reg;
    logic [7:0] blank_ext;
    logic [7:0] disp_ext;
    logic [7:0] start_addr_ext;
    logic half_phase;
    logic [3:0] dot_cnt;
    logic [8:0] char_cnt;
    logic [9:0] scan_cnt;
    logic char_tick;
    logic hdisp;
    logic hblank;
    logic line_end;
    logic vretr;
    logic [19:0] start_addr;
    logic rd_p1;
    logic rd_local_p1;
    logic [7:0] local_data_p1;
    logic [7:0] rdata;
    logic rvalid;
    logic ext_acc;
  } crtch_state_t;

  crtch_state_t s_ff;
  crtch_state_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // Index decode helpers

  function automatic logic is_ext_index(input logic [5:0] idx);
    return idx inside {crtch_pkg::IDX_EXT_A, crtch_pkg::IDX_BLANKING_EXTENSION,
                       crtch_pkg::IDX_DISPLAY_EXTENSION, crtch_pkg::IDX_EXT_D,
                       crtch_pkg::IDX_EXT_E};
  endfunction

  function automatic logic is_protected(input logic [5:0] idx);
    return idx <= crtch_pkg::IDX_PROTECT_LAST;
  endfunction

  // Registers the timing logic needs in parallel live in flops
  function automatic logic is_local(input logic [5:0] idx);
    return idx inside {crtch_pkg::IDX_HORIZONTAL_TOTAL, crtch_pkg::IDX_HORIZONTAL_DISPLAY_END,
                       crtch_pkg::IDX_HORIZONTAL_BLANKING_START,
                       crtch_pkg::IDX_HORIZONTAL_BLANKING_END,
                       crtch_pkg::IDX_HORIZONTAL_SYNC_END, crtch_pkg::IDX_VERTICAL_TOTAL,
                       crtch_pkg::IDX_VERTICAL_OVERFLOW, crtch_pkg::IDX_START_ADDRESS_HIGH,
                       crtch_pkg::IDX_START_ADDRESS_LOW, crtch_pkg::IDX_VERTICAL_SYNC_END,
                       crtch_pkg::IDX_BLANKING_EXTENSION, crtch_pkg::IDX_DISPLAY_EXTENSION,
                       crtch_pkg::IDX_START_ADDRESS_EXT};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decode

  logic [15:0] index_port;
  logic [15:0] data_port;
  logic idx_wr;
  logic idx_rd;
  logic dat_wr;
  logic dat_rd;
  logic wr_blocked;
  logic mem_wr;
  logic [7:0] mem_rdata;
  logic [9:0] vtotal_full;
  logic [7:0] hbe_field;
  logic hbe_wide;
  logic [3:0] dot_last;
  logic dot_en;
  logic tick_now;
  logic wrap_now;
  logic [8:0] nc;
  logic [9:0] ns;
  logic hbe_match;

  always_comb begin
    index_port = color_select_i ? crtch_pkg::PORT_INDEX_COLOR
                                : crtch_pkg::PORT_INDEX_MONO;
    data_port = color_select_i ? crtch_pkg::PORT_DATA_COLOR : crtch_pkg::PORT_DATA_MONO;
    idx_wr = io_wr_i && (io_addr_i == index_port);
    idx_rd = io_rd_i && (io_addr_i == index_port);
    dat_wr = io_wr_i && (io_addr_i == data_port);
    dat_rd = io_rd_i && (io_addr_i == data_port);
    wr_blocked = is_protected(s_ff.index)
                 && s_ff.vsync_end_reg[crtch_pkg::WRITE_PROTECT_BIT];
    mem_wr = dat_wr && !is_local(s_ff.index) && !wr_blocked;
    vtotal_full = {s_ff.vert_overflow[crtch_pkg::VT_BIT9_POS],
                   s_ff.vert_overflow[crtch_pkg::VT_BIT8_POS], s_ff.vtotal_reg};
    hbe_field = {s_ff.blank_ext[5:4], s_ff.hsync_end_reg[crtch_pkg::HBE_BIT5_POS],
                 s_ff.hblank_end_reg[4:0]};
    hbe_wide = s_ff.disp_ext[crtch_pkg::HBE_WIDE_EN_A_POS]
               || s_ff.disp_ext[crtch_pkg::HBE_WIDE_EN_B_POS];
    dot_last = char_width_8_i ? crtch_pkg::DOT_LAST_8 : crtch_pkg::DOT_LAST_9;
    dot_en = !dot_clock_half_i || s_ff.half_phase;
    tick_now = dot_en && (s_ff.dot_cnt >= dot_last);
    // Compare with >= so a lowered total cannot let the counter run away
    wrap_now = s_ff.char_cnt >= ({1'b0, s_ff.htotal} + crtch_pkg::HTOTAL_OFFSET
                                 - 9'h001);
    nc = wrap_now ? 9'h000 : s_ff.char_cnt + 9'h001;
    ns = (s_ff.scan_cnt >= vtotal_full + 10'h001) ? 10'h000 : s_ff.scan_cnt + 10'h001;
    hbe_match = hbe_wide ? (nc[7:0] == hbe_field)
                         : (nc[5:0] == hbe_field[5:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_s = s_ff;
    nxt_s.char_tick = 1'b0;
    nxt_s.line_end = 1'b0;
    nxt_s.vretr = 1'b0;
    nxt_s.ext_acc = 1'b0;
    nxt_s.rvalid = 1'b0;

    // Host register writes
    if (idx_wr) begin
      nxt_s.index = io_wdata_i[5:0];
    end
    if (dat_wr && !wr_blocked) begin
      unique case (s_ff.index)
        crtch_pkg::IDX_HORIZONTAL_TOTAL: nxt_s.htotal = io_wdata_i;
        crtch_pkg::IDX_HORIZONTAL_DISPLAY_END: nxt_s.hdisp_end = io_wdata_i;
        crtch_pkg::IDX_HORIZONTAL_BLANKING_START: nxt_s.hblank_start = io_wdata_i;
        crtch_pkg::IDX_HORIZONTAL_BLANKING_END: nxt_s.hblank_end_reg = io_wdata_i;
        crtch_pkg::IDX_HORIZONTAL_SYNC_END: nxt_s.hsync_end_reg = io_wdata_i;
        crtch_pkg::IDX_VERTICAL_TOTAL: nxt_s.vtotal_reg = io_wdata_i;
        crtch_pkg::IDX_VERTICAL_OVERFLOW: nxt_s.vert_overflow = io_wdata_i;
        crtch_pkg::IDX_START_ADDRESS_HIGH: nxt_s.start_addr_high = io_wdata_i;
        crtch_pkg::IDX_START_ADDRESS_LOW: nxt_s.start_addr_low = io_wdata_i;
        crtch_pkg::IDX_VERTICAL_SYNC_END: nxt_s.vsync_end_reg = io_wdata_i;
        crtch_pkg::IDX_BLANKING_EXTENSION: nxt_s.blank_ext = io_wdata_i;
        crtch_pkg::IDX_DISPLAY_EXTENSION: nxt_s.disp_ext = io_wdata_i;
        crtch_pkg::IDX_START_ADDRESS_EXT: nxt_s.start_addr_ext = io_wdata_i;
        default: ;
      endcase
    end
    if ((dat_wr || dat_rd) && is_ext_index(s_ff.index)) begin
      nxt_s.ext_acc = 1'b1;
    end

    // Reads: flop registers answer locally, the rest come from the memory
    nxt_s.rd_p1 = idx_rd || dat_rd;
    nxt_s.rd_local_p1 = idx_rd || is_local(s_ff.index);
    unique case (s_ff.index)
      crtch_pkg::IDX_HORIZONTAL_TOTAL: nxt_s.local_data_p1 = s_ff.htotal;
      crtch_pkg::IDX_HORIZONTAL_DISPLAY_END: nxt_s.local_data_p1 = s_ff.hdisp_end;
      crtch_pkg::IDX_HORIZONTAL_BLANKING_START: nxt_s.local_data_p1 = s_ff.hblank_start;
      crtch_pkg::IDX_HORIZONTAL_BLANKING_END: nxt_s.local_data_p1 = s_ff.hblank_end_reg;
      crtch_pkg::IDX_HORIZONTAL_SYNC_END: nxt_s.local_data_p1 = s_ff.hsync_end_reg;
      crtch_pkg::IDX_VERTICAL_TOTAL: nxt_s.local_data_p1 = s_ff.vtotal_reg;
      crtch_pkg::IDX_VERTICAL_OVERFLOW: nxt_s.local_data_p1 = s_ff.vert_overflow;
      crtch_pkg::IDX_START_ADDRESS_HIGH: nxt_s.local_data_p1 = s_ff.start_addr_high;
      crtch_pkg::IDX_START_ADDRESS_LOW: nxt_s.local_data_p1 = s_ff.start_addr_low;
      crtch_pkg::IDX_VERTICAL_SYNC_END: nxt_s.local_data_p1 = s_ff.vsync_end_reg;
      crtch_pkg::IDX_BLANKING_EXTENSION: nxt_s.local_data_p1 = s_ff.blank_ext;
      crtch_pkg::IDX_DISPLAY_EXTENSION: nxt_s.local_data_p1 = s_ff.disp_ext;
      crtch_pkg::IDX_START_ADDRESS_EXT: nxt_s.local_data_p1 = s_ff.start_addr_ext;
      default: nxt_s.local_data_p1 = crtch_pkg::REG_RESET;
    endcase
    if (idx_rd) begin
      nxt_s.local_data_p1 = {2'b00, s_ff.index};
    end
    if (s_ff.rd_p1) begin
      nxt_s.rdata = s_ff.rd_local_p1 ? s_ff.local_data_p1 : mem_rdata;
      nxt_s.rvalid = 1'b1;
    end

    // Character clock from the master clock
    nxt_s.half_phase = !s_ff.half_phase;
    if (dot_en) begin
      nxt_s.dot_cnt = tick_now ? 4'h0 : s_ff.dot_cnt + 4'h1;
    end

    // Horizontal timing in characters, vertical in lines
    if (tick_now) begin
      nxt_s.char_tick = 1'b1;
      nxt_s.char_cnt = nc;
      nxt_s.hdisp = (nc <= {1'b0, s_ff.hdisp_end});
      if (nc == {1'b0, s_ff.hblank_start}) begin
        nxt_s.hblank = 1'b1;
      end else if (hbe_match) begin
        nxt_s.hblank = 1'b0;
      end
      if (wrap_now) begin
        nxt_s.line_end = 1'b1;
        nxt_s.scan_cnt = ns;
        nxt_s.vretr = (ns == vtotal_full);
      end
    end

    nxt_s.start_addr = {s_ff.start_addr_ext[7], s_ff.disp_ext[3], s_ff.disp_ext[2],
                        s_ff.disp_ext[0], s_ff.start_addr_high,
                        s_ff.start_addr_low};
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  crtch_regmem #(
    .ADDR_W(6),
    .DATA_W(8)
  ) u_regmem (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(mem_wr),
    .wr_addr_i(s_ff.index),
    .wr_data_i(io_wdata_i),
    .rd_addr_i(s_ff.index),
    .rd_data_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign io_rdata_o = s_ff.rdata;
  assign io_rvalid_o = s_ff.rvalid;
  assign ext_access_o = s_ff.ext_acc;
  assign char_tick_o = s_ff.char_tick;
  assign char_count_o = s_ff.char_cnt;
  assign hdisplay_o = s_ff.hdisp;
  assign hblank_o = s_ff.hblank;
  assign line_end_o = s_ff.line_end;
  assign scanline_o = s_ff.scan_cnt;
  assign vretrace_start_o = s_ff.vretr;
  assign start_address_o = s_ff.start_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_index_read;
    io_rd_i && (io_addr_i == index_port);
  endsequence

  sequence s_read_answer;
    !io_rvalid_o ##1 io_rvalid_o;
  endsequence

  property p_index_write;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    idx_wr |=> (s_ff.index == $past(io_wdata_i[5:0]));
  endproperty
  a_index_write: assert property (p_index_write) else $error("index not loaded");

  property p_port_select;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (io_wr_i && !color_select_i && (io_addr_i == crtch_pkg::PORT_INDEX_COLOR))
      |=> $stable(s_ff.index);
  endproperty
  a_port_select: assert property (p_port_select) else $error("colour port hit in mono");

  property p_ext_route;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_wr && is_ext_index(s_ff.index)) |=> ext_access_o;
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("extension access missed");

  property p_char_spacing;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    char_tick_o |=> !char_tick_o [*7];
  endproperty
  a_char_spacing: assert property (p_char_spacing) else $error("character clock too fast");

  property p_char_count;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (char_tick_o && !line_end_o) |-> (char_count_o == $past(char_count_o) + 9'h001);
  endproperty
  a_char_count: assert property (p_char_count) else $error("character count skipped");

  property p_line_wrap;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    line_end_o |-> (char_count_o == 9'h000) && ($past(char_count_o)
      >= {1'b0, $past(s_ff.htotal)} + crtch_pkg::HTOTAL_OFFSET - 9'h001);
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line period wrong");

  property p_scan_advance;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(scanline_o) |-> line_end_o;
  endproperty
  a_scan_advance: assert property (p_scan_advance) else $error("scanline moved mid-line");

  property p_hdisplay;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (char_tick_o && $stable(s_ff.hdisp_end))
      |-> (hdisplay_o == (char_count_o <= {1'b0, s_ff.hdisp_end}));
  endproperty
  a_hdisplay: assert property (p_hdisplay) else $error("display end wrong");

  property p_hblank_start;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (char_tick_o && $stable(s_ff.hblank_start)
      && (char_count_o == {1'b0, s_ff.hblank_start})) |-> hblank_o;
  endproperty
  a_hblank_start: assert property (p_hblank_start) else $error("blanking did not start");

  property p_hblank_end;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    // The compare used the field as it stood before the clearing edge
    ($fell(hblank_o) && !$past(hbe_wide)) |-> (char_count_o[5:0] == $past(hbe_field[5:0]));
  endproperty
  a_hblank_end: assert property (p_hblank_end) else $error("blanking ended early");

  property p_write_protect;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (dat_wr && s_ff.vsync_end_reg[crtch_pkg::WRITE_PROTECT_BIT]
      && (s_ff.index <= crtch_pkg::IDX_HORIZONTAL_BLANKING_START))
      |=> $stable(s_ff.htotal) && $stable(s_ff.hdisp_end) && $stable(s_ff.hblank_start);
  endproperty
  a_write_protect: assert property (p_write_protect) else $error("protected write landed");

  property p_vretrace;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    vretrace_start_o |-> line_end_o && (scanline_o == $past(vtotal_full));
  endproperty
  a_vretrace: assert property (p_vretrace) else $error("retrace at wrong line");

  property p_index_readback;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_index_read ##0 (!io_rvalid_o && !s_ff.rd_p1) |=> s_read_answer
      ##0 (io_rdata_o == {2'b00, $past(s_ff.index, 2)});
  endproperty
  a_index_readback: assert property (p_index_readback) else $error("index readback wrong");

endmodule // crtch_top
